//--- inc/odt_defs.vh
// Constants for the on-delay and off-delay timer blocks.
`ifndef ODT_DEFS_VH
`define ODT_DEFS_VH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define ODT_CLK_PERIOD_NS   10
`define ODT_TICK_PERIOD_NS  10000000
`define ODT_TICKS_PER_S     100
`define ODT_S_PER_MIN       60
`define ODT_MS_PER_TICK     17'h0000A

// ---------------------------------------------------------------------------
// Timebase codes and delay limits
// ---------------------------------------------------------------------------
`define ODT_TB_FINE         2'h0
`define ODT_TB_SEC          2'h1
`define ODT_TB_MIN          2'h2
`define ODT_MAX_CONST_FINE  17'h0270F
`define ODT_MAX_CONST_COARSE 17'h0176F
`define ODT_MAX_BLK_MS      32'h00018696
`define ODT_MAX_BLK_COARSE  32'h0000176F

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define ODT_OFS_ON_CFG      8'h00
`define ODT_OFS_ON_DELAY    8'h04
`define ODT_OFS_OFF_CFG     8'h08
`define ODT_OFS_OFF_DELAY   8'h0C
`define ODT_OFS_STATUS      8'h10
`define ODT_OFS_ON_ELAPSED  8'h14
`define ODT_OFS_OFF_ELAPSED 8'h18

// ---------------------------------------------------------------------------
// Configuration register fields and reset values
// ---------------------------------------------------------------------------
`define ODT_CFG_TB_LSB      0
`define ODT_CFG_TB_MSB      1
`define ODT_CFG_SRC_BIT     2
`define ODT_CFG_RETAIN_BIT  3
`define ODT_CFG_BLK_LSB     8
`define ODT_CFG_BLK_MSB     15
`define ODT_CFG_MASK        32'h0000FF0F
`define ODT_DELAY_MASK      32'h0000FFFF
`define ODT_CFG_RESET       32'h00000000
`define ODT_DELAY_RESET     32'h00000000

`endif

//--- hw/odt_tick.v
// Timebase prescaler producing 10 ms, 1 s and 1 min tick pulses.
`timescale 1ns/1ps
`include "odt_defs.vh"

module odt_tick #(
  parameter integer TICK_CYCLES = `ODT_TICK_PERIOD_NS / `ODT_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Tick pulses
  output reg  tick_fine_o,
  output reg  tick_sec_o,
  output reg  tick_min_o
);

  reg [31:0] pre_reg;
  reg [7:0]  fine_reg;
  reg [7:0]  sec_reg;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_reg     <= 32'h00000000;
      fine_reg    <= 8'h00;
      sec_reg     <= 8'h00;
      tick_fine_o <= 1'b0;
      tick_sec_o  <= 1'b0;
      tick_min_o  <= 1'b0;
    end
    else
    begin
      tick_fine_o <= 1'b0;
      tick_sec_o  <= 1'b0;
      tick_min_o  <= 1'b0;
      if (pre_reg >= TICK_CYCLES - 1)
      begin
        pre_reg     <= 32'h00000000;
        tick_fine_o <= 1'b1;
        if (fine_reg == `ODT_TICKS_PER_S - 1)
        begin
          fine_reg   <= 8'h00;
          tick_sec_o <= 1'b1;
          if (sec_reg == `ODT_S_PER_MIN - 1)
          begin
            sec_reg    <= 8'h00;
            tick_min_o <= 1'b1;
          end
          else
            sec_reg <= sec_reg + 8'h01;
        end
        else
          fine_reg <= fine_reg + 8'h01;
      end
      else
        pre_reg <= pre_reg + 32'h00000001;
    end
  end

endmodule

//--- hw/odt_dly_sel.v
// Delay source selection: constant or another block's live value, clamped.
`timescale 1ns/1ps
`include "odt_defs.vh"

module odt_dly_sel #(
  parameter integer NBLK = 8
) (
  // Configuration
  input  wire [1:0]         tb_i,
  input  wire               src_blk_i,
  input  wire [15:0]        const_i,
  input  wire [7:0]         blk_num_i,
  // Live block values, signed 32 bits each
  input  wire [NBLK*32-1:0] blk_values_i,
  // Delay in timebase units
  output reg  [16:0]        delay_o
);

  reg signed [31:0] analog_input_value;
  reg        [31:0] blk_clamped;
  reg        [16:0] const_clamped;
  integer           i;

  always @*
  begin
    analog_input_value = 32'sh00000000;
    for (i = 0; i < NBLK; i = i + 1)
      if (blk_num_i == i[7:0])
        analog_input_value = blk_values_i[i*32 +: 32];
    // Out-of-range values snap to the nearest limit.
    if (analog_input_value < 0)
      blk_clamped = 32'h00000000;
    else if (tb_i == `ODT_TB_FINE && analog_input_value > $signed(`ODT_MAX_BLK_MS))
      blk_clamped = `ODT_MAX_BLK_MS;
    else if (tb_i != `ODT_TB_FINE && analog_input_value > $signed(`ODT_MAX_BLK_COARSE))
      blk_clamped = `ODT_MAX_BLK_COARSE;
    else
      blk_clamped = analog_input_value;
    if (tb_i == `ODT_TB_FINE && {1'b0, const_i} > `ODT_MAX_CONST_FINE)
      const_clamped = `ODT_MAX_CONST_FINE;
    else if (tb_i != `ODT_TB_FINE && {1'b0, const_i} > `ODT_MAX_CONST_COARSE)
      const_clamped = `ODT_MAX_CONST_COARSE;
    else
      const_clamped = {1'b0, const_i};
    if (!src_blk_i)
      delay_o = const_clamped;
    else if (tb_i == `ODT_TB_FINE)
      delay_o = blk_clamped[16:0] / `ODT_MS_PER_TICK;
    else
      delay_o = blk_clamped[16:0];
  end

endmodule

//--- hw/odt_top.v
// On-delay and off-delay timer blocks with a Wishbone register file.
//
// Overview of operation
// [RULE1] On-delay restarts its elapsed time from zero on a trigger rising edge.
// [RULE2] On-delay output rises once elapsed time reaches delay with trigger held high.
// [RULE3] Trigger falling before expiry clears on-delay elapsed time, output stays low.
// [RULE4] On-delay output is low whenever its trigger is low, without delay.
// [RULE5] Power loss clears output and elapsed time unless retain is set.
// [RULE6] Constant delays: seconds to 99:99 by 10 ms, minutes and hours to 99:59.
// [RULE7] Block values read as ms up to 99990, seconds or minutes up to 5999.
// [RULE8] Out-of-range block values are clamped to the nearest valid limit.
// [RULE9] Delay source is a constant or a numbered block value, with a timebase.
// [RULE10] Off-delay output rises at once when its trigger goes high.
// [RULE11] Off-delay restarts elapsed time on trigger falling edge, output stays high.
// [RULE12] Off-delay output falls when elapsed time equals the delay.
// [RULE13] A new trigger during an off-delay restarts timing, pushing expiry back.
// [RULE14] Off-delay clear input resets elapsed time and forces the output low.
// [RULE15] Elapsed counters advance on a 10 ms tick with second and minute prescales.
`timescale 1ns/1ps
`include "odt_defs.vh"

module odt_top #(
  parameter integer NBLK        = 8,
  parameter integer TICK_CYCLES = `ODT_TICK_PERIOD_NS / `ODT_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire               clk_i,
  input  wire               rst_i,
  // Wishbone slave
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  input  wire               wb_we_i,
  input  wire [7:0]         wb_adr_i,
  input  wire [3:0]         wb_sel_i,
  input  wire [31:0]        wb_dat_i,
  output reg  [31:0]        wb_dat_o,
  output reg                wb_ack_o,
  // Neighbouring logic
  input  wire               on_trig_i,
  input  wire               off_trig_i,
  input  wire               off_clr_i,
  input  wire               pwr_loss_i,
  input  wire [NBLK*32-1:0] blk_values_i,
  // Delayed outputs
  output reg                on_q_o,
  output reg                off_q_o
);

  // -------------------------------------------------------------------------
  // States
  // -------------------------------------------------------------------------
  localparam [2:0] ON_IDLE  = 3'h1;
  localparam [2:0] ON_RUN   = 3'h2;
  localparam [2:0] ON_HIGH  = 3'h4;
  localparam [2:0] OFF_IDLE = 3'h1;
  localparam [2:0] OFF_HELD = 3'h2;
  localparam [2:0] OFF_RUN  = 3'h4;

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------
  function [31:0] wb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    input [31:0] mask;
    integer      b;
    begin
      wb_merge = old_val;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          wb_merge[b*8 +: 8] = new_val[b*8 +: 8];
      wb_merge = wb_merge & mask;
    end
  endfunction

  function tb_tick;
    input [1:0] tb;
    input       t_fine;
    input       t_sec;
    input       t_min;
    begin
      case (tb)
        `ODT_TB_FINE: tb_tick = t_fine;
        `ODT_TB_SEC:  tb_tick = t_sec;
        default:      tb_tick = t_min;
      endcase
    end
  endfunction

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  reg  [31:0] on_cfg_reg;
  reg  [31:0] on_dly_reg;
  reg  [31:0] off_cfg_reg;
  reg  [31:0] off_dly_reg;
  reg  [2:0]  on_state_reg;
  reg  [2:0]  on_state_next;
  reg  [16:0] on_elapsed_time_reg;
  reg  [16:0] on_elapsed_time_next;
  reg         on_q_next;
  reg  [2:0]  off_state_reg;
  reg  [2:0]  off_state_next;
  reg  [16:0] off_elapsed_time_reg;
  reg  [16:0] off_elapsed_time_next;
  reg         off_q_next;
  reg         on_trig_prev_reg;
  reg  [31:0] rd_data;
  wire        tick_fine;
  wire        tick_sec;
  wire        tick_min;
  wire [16:0] on_delay;
  wire [16:0] off_delay;
  wire [1:0]  on_tb;
  wire [1:0]  off_tb;
  wire        on_retain;
  wire        off_retain;
  wire        on_tick;
  wire        off_tick;
  wire        wb_req;

  assign on_tb      = (on_cfg_reg[`ODT_CFG_TB_MSB:`ODT_CFG_TB_LSB] == 2'h3) ? `ODT_TB_MIN
                    : on_cfg_reg[`ODT_CFG_TB_MSB:`ODT_CFG_TB_LSB];
  assign off_tb     = (off_cfg_reg[`ODT_CFG_TB_MSB:`ODT_CFG_TB_LSB] == 2'h3) ? `ODT_TB_MIN
                    : off_cfg_reg[`ODT_CFG_TB_MSB:`ODT_CFG_TB_LSB];
  assign on_retain  = on_cfg_reg[`ODT_CFG_RETAIN_BIT];
  assign off_retain = off_cfg_reg[`ODT_CFG_RETAIN_BIT];
  assign on_tick    = tb_tick(on_tb, tick_fine, tick_sec, tick_min);   // [RULE15]
  assign off_tick   = tb_tick(off_tb, tick_fine, tick_sec, tick_min);  // [RULE15]
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // -------------------------------------------------------------------------
  // Timebase and delay sources
  // -------------------------------------------------------------------------
  odt_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .tick_fine_o (tick_fine),
    .tick_sec_o  (tick_sec),
    .tick_min_o  (tick_min)
  );

  // Constant or block value, per timebase, clamped. [RULE6] [RULE7] [RULE8] [RULE9]
  odt_dly_sel #(
    .NBLK         (NBLK)
  ) u_on_sel (
    .tb_i         (on_tb),
    .src_blk_i    (on_cfg_reg[`ODT_CFG_SRC_BIT]),
    .const_i      (on_dly_reg[15:0]),
    .blk_num_i    (on_cfg_reg[`ODT_CFG_BLK_MSB:`ODT_CFG_BLK_LSB]),
    .blk_values_i (blk_values_i),
    .delay_o      (on_delay)
  );

  odt_dly_sel #(
    .NBLK         (NBLK)
  ) u_off_sel (
    .tb_i         (off_tb),
    .src_blk_i    (off_cfg_reg[`ODT_CFG_SRC_BIT]),
    .const_i      (off_dly_reg[15:0]),
    .blk_num_i    (off_cfg_reg[`ODT_CFG_BLK_MSB:`ODT_CFG_BLK_LSB]),
    .blk_values_i (blk_values_i),
    .delay_o      (off_delay)
  );

  // -------------------------------------------------------------------------
  // On-delay timer
  // -------------------------------------------------------------------------
  always @*
  begin
    on_state_next        = on_state_reg;
    on_elapsed_time_next = on_elapsed_time_reg;
    on_q_next            = on_q_o;
    if (pwr_loss_i)
    begin
      // A retained timer freezes for the whole power loss.
      if (!on_retain)
      begin
        on_state_next        = ON_IDLE;                                  // [RULE5]
        on_elapsed_time_next = 17'h00000;                                // [RULE5]
        on_q_next            = 1'b0;                                     // [RULE5]
      end
    end
    else
    begin
      case (on_state_reg)
        ON_IDLE:
        begin
          on_q_next = 1'b0;
          if (on_trig_i && !on_trig_prev_reg)
          begin
            on_elapsed_time_next = 17'h00000;                            // [RULE1]
            on_state_next        = ON_RUN;
          end
        end
        ON_RUN:
        begin
          if (!on_trig_i)
          begin
            on_elapsed_time_next = 17'h00000;                            // [RULE3]
            on_state_next        = ON_IDLE;
          end
          else if (on_elapsed_time_reg >= on_delay)
          begin
            on_q_next     = 1'b1;                                        // [RULE2]
            on_state_next = ON_HIGH;
          end
          else if (on_tick)
            on_elapsed_time_next = on_elapsed_time_reg + 17'h00001;      // [RULE15]
        end
        ON_HIGH:
        begin
          if (!on_trig_i)
          begin
            on_q_next     = 1'b0;                                        // [RULE4]
            on_state_next = ON_IDLE;
          end
        end
        default:
        begin
          on_state_next        = ON_IDLE;
          on_elapsed_time_next = 17'h00000;
          on_q_next            = 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Off-delay timer
  // -------------------------------------------------------------------------
  always @*
  begin
    off_state_next        = off_state_reg;
    off_elapsed_time_next = off_elapsed_time_reg;
    off_q_next            = off_q_o;
    if (pwr_loss_i)
    begin
      if (!off_retain)
      begin
        off_state_next        = OFF_IDLE;                                // [RULE5]
        off_elapsed_time_next = 17'h00000;                               // [RULE5]
        off_q_next            = 1'b0;                                    // [RULE5]
      end
    end
    else if (off_clr_i)
    begin
      off_state_next        = OFF_IDLE;                                  // [RULE14]
      off_elapsed_time_next = 17'h00000;                                 // [RULE14]
      off_q_next            = 1'b0;                                      // [RULE14]
    end
    else
    begin
      case (off_state_reg)
        OFF_IDLE:
        begin
          if (off_trig_i)
          begin
            off_q_next     = 1'b1;                                       // [RULE10]
            off_state_next = OFF_HELD;
          end
        end
        OFF_HELD:
        begin
          off_q_next = 1'b1;
          if (!off_trig_i)
          begin
            off_elapsed_time_next = 17'h00000;                           // [RULE11]
            off_state_next        = OFF_RUN;
          end
        end
        OFF_RUN:
        begin
          if (off_trig_i)
          begin
            off_elapsed_time_next = 17'h00000;                           // [RULE13]
            off_state_next        = OFF_HELD;
          end
          else if (off_elapsed_time_reg >= off_delay)
          begin
            off_q_next     = 1'b0;                                       // [RULE12]
            off_state_next = OFF_IDLE;
          end
          else if (off_tick)
            off_elapsed_time_next = off_elapsed_time_reg + 17'h00001;    // [RULE15]
        end
        default:
        begin
          off_state_next        = OFF_IDLE;
          off_elapsed_time_next = 17'h00000;
          off_q_next            = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      on_state_reg         <= ON_IDLE;
      on_elapsed_time_reg  <= 17'h00000;
      on_q_o               <= 1'b0;
      on_trig_prev_reg     <= 1'b0;
      off_state_reg        <= OFF_IDLE;
      off_elapsed_time_reg <= 17'h00000;
      off_q_o              <= 1'b0;
    end
    else
    begin
      on_state_reg         <= on_state_next;
      on_elapsed_time_reg  <= on_elapsed_time_next;
      on_q_o               <= on_q_next;
      on_trig_prev_reg     <= on_trig_i;
      off_state_reg        <= off_state_next;
      off_elapsed_time_reg <= off_elapsed_time_next;
      off_q_o              <= off_q_next;
    end
  end

  // -------------------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------------------
  always @*
  begin
    case (wb_adr_i)
      `ODT_OFS_ON_CFG:      rd_data = on_cfg_reg;
      `ODT_OFS_ON_DELAY:    rd_data = on_dly_reg;
      `ODT_OFS_OFF_CFG:     rd_data = off_cfg_reg;
      `ODT_OFS_OFF_DELAY:   rd_data = off_dly_reg;
      `ODT_OFS_STATUS:      rd_data = {24'h000000, off_state_reg, on_state_reg, off_q_o, on_q_o};
      `ODT_OFS_ON_ELAPSED:  rd_data = {15'h0000, on_elapsed_time_reg};
      `ODT_OFS_OFF_ELAPSED: rd_data = {15'h0000, off_elapsed_time_reg};
      default:              rd_data = 32'h00000000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      on_cfg_reg  <= `ODT_CFG_RESET;
      on_dly_reg  <= `ODT_DELAY_RESET;
      off_cfg_reg <= `ODT_CFG_RESET;
      off_dly_reg <= `ODT_DELAY_RESET;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= rd_data;
      if (wb_req && wb_we_i)
      begin
        case (wb_adr_i)
          `ODT_OFS_ON_CFG:    on_cfg_reg  <= wb_merge(on_cfg_reg, wb_dat_i, wb_sel_i, `ODT_CFG_MASK);
          `ODT_OFS_ON_DELAY:  on_dly_reg  <= wb_merge(on_dly_reg, wb_dat_i, wb_sel_i, `ODT_DELAY_MASK);
          `ODT_OFS_OFF_CFG:   off_cfg_reg <= wb_merge(off_cfg_reg, wb_dat_i, wb_sel_i, `ODT_CFG_MASK);
          `ODT_OFS_OFF_DELAY: off_dly_reg <= wb_merge(off_dly_reg, wb_dat_i, wb_sel_i, `ODT_DELAY_MASK);
          default:
          begin
          end
        endcase
      end
    end
  end

endmodule

//--- test/odt_top_properties.sv
// Concurrent checks on the ports of the timer block top level.
`timescale 1ns/1ps
module odt_top_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Neighbouring logic
  input wire logic on_trig_i,
  input wire logic off_trig_i,
  input wire logic off_clr_i,
  input wire logic pwr_loss_i,
  // Delayed outputs
  input wire logic on_q_o,
  input wire logic off_q_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------------------
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  wb_ack_once_a:
    assert property (wb_req_s |=> ack_pulse_s) else $error("bus answer is not a single ack pulse");
  wb_ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack without request");
  on_low_a:
    assert property (!on_trig_i && !pwr_loss_i |=> !on_q_o) else $error("on output high with trigger low");
  on_rise_a:
    assert property ($rose(on_q_o) |-> $past(on_trig_i) && $past(on_trig_i, 2)) else $error("on output rose early");
  on_start_a:
    assert property ($rose(on_trig_i) && !pwr_loss_i && !$past(pwr_loss_i) |=> !on_q_o)
      else $error("on output high at trigger rise");
  off_set_a:
    assert property (off_trig_i && !off_clr_i && !pwr_loss_i |=> off_q_o) else $error("off output not set");
  off_hold_a:
    assert property ($fell(off_trig_i) && off_q_o && !off_clr_i && !pwr_loss_i |=> off_q_o)
      else $error("off output dropped at trigger fall");
  off_fall_a:
    assert property ($fell(off_q_o) && !$past(off_clr_i) && !$past(pwr_loss_i)
      |-> !$past(off_trig_i) && !$past(off_trig_i, 2)) else $error("off output fell too soon");
  off_clear_a:
    assert property (off_clr_i && !pwr_loss_i |=> !off_q_o) else $error("clear did not drop off output");
endmodule

bind odt_top odt_top_properties odt_top_properties_inst (
  .clk_i      (clk_i),
  .rst_i      (rst_i),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_ack_o   (wb_ack_o),
  .on_trig_i  (on_trig_i),
  .off_trig_i (off_trig_i),
  .off_clr_i  (off_clr_i),
  .pwr_loss_i (pwr_loss_i),
  .on_q_o     (on_q_o),
  .off_q_o    (off_q_o)
);

//--- test/odt_nbr_model.sv
// Model of the neighbouring logic blocks that feed the timer blocks.
`timescale 1ns/1ps
module odt_nbr_model #(
  parameter integer NBLK = 8
) (
  // Lines to the timer blocks
  output logic              on_trig_o,
  output logic              off_trig_o,
  output logic              off_clr_o,
  output logic              pwr_loss_o,
  output logic [NBLK*32-1:0] blk_values_o
);
  initial
  begin
    {on_trig_o, off_trig_o, off_clr_o, pwr_loss_o} = 4'h0;
    blk_values_o = '0;
  end
  // Callers are at a rising edge, so lines change just after it.
  task automatic drive(input logic [3:0] v);
    {on_trig_o, off_trig_o, off_clr_o, pwr_loss_o} <= v;
  endtask
  task automatic set_blk(input int n, input logic [31:0] v);
    blk_values_o[n*32 +: 32] <= v;
  endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the on-delay and off-delay timer blocks.
`timescale 1ns/1ps
`include "odt_defs.vh"
module tb_top;
  localparam integer TC = 4;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic         on_trig_i, off_trig_i, off_clr_i, pwr_loss_i, on_q_o, off_q_o;
  logic [7:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o;
  logic [255:0] blk_values_i;
  int           errors = 0;
  int           cmp_count = 0;

  odt_top #(.NBLK(8), .TICK_CYCLES(TC)) odt_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .on_trig_i(on_trig_i), .off_trig_i(off_trig_i), .off_clr_i(off_clr_i),
    .pwr_loss_i(pwr_loss_i), .blk_values_i(blk_values_i), .on_q_o(on_q_o), .off_q_o(off_q_o));
  odt_nbr_model #(.NBLK(8)) odt_nbr_model_inst (
    .on_trig_o(on_trig_i), .off_trig_o(off_trig_i), .off_clr_o(off_clr_i),
    .pwr_loss_o(pwr_loss_i), .blk_values_o(blk_values_i));

  initial
  begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 20);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (wb_ack_o !== 1'h1)
    begin
      errors++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'h0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // Counts edges until the chosen output shows v; it must not show it before lo.
  task automatic wait_q(input int s, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while ((s ? off_q_o : on_q_o) !== v && n <= hi);
    chk((n < lo || n > hi) ? n : lo, lo);
    if (n > hi)
    begin
      tally_and_finish();
    end
  endtask
  task automatic drv(input logic [3:0] v);
    odt_nbr_model_inst.drive(v);
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic sc_regs;
    rd(`ODT_OFS_ON_CFG, `ODT_CFG_RESET);
    wr(`ODT_OFS_ON_CFG, 32'hFFFFFFFF);
    rd(`ODT_OFS_ON_CFG, `ODT_CFG_MASK);
    wr(`ODT_OFS_ON_DELAY, 32'h00012345);
    rd(`ODT_OFS_ON_DELAY, 32'h00012345 & `ODT_DELAY_MASK);
    rd(8'h1C, 32'h0);
    wr(`ODT_OFS_ON_CFG, 32'h0);
    wr(`ODT_OFS_ON_DELAY, 32'h5);
    wr(`ODT_OFS_OFF_DELAY, 32'h5);
  endtask
  task automatic sc_on;
    drv(4'h8);
    wait_q(0, 1'h1, 4 * TC, 6 * TC + 4);
    drv(4'h0);
    wait_q(0, 1'h0, 2, 2);
    drv(4'h8);
    repeat (3 * TC) @(posedge clk_i);
    drv(4'h0);
    repeat (2) @(posedge clk_i);
    rd(`ODT_OFS_ON_ELAPSED, 32'h0);
    drv(4'h8);
    wait_q(0, 1'h1, 4 * TC, 6 * TC + 4);
    drv(4'h0);
    wait_q(0, 1'h0, 2, 2);
  endtask
  task automatic sc_off;
    drv(4'h4);
    wait_q(1, 1'h1, 2, 2);
    drv(4'h0);
    wait_q(1, 1'h0, 4 * TC, 6 * TC + 4);
    drv(4'h4);
    @(posedge clk_i);
    drv(4'h0);
    repeat (14) @(posedge clk_i);
    drv(4'h4);
    @(posedge clk_i);
    drv(4'h0);
    wait_q(1, 1'h0, 4 * TC, 6 * TC + 4);
    drv(4'h4);
    wait_q(1, 1'h1, 2, 2);
    drv(4'h0);
    repeat (4) @(posedge clk_i);
    drv(4'h2);
    wait_q(1, 1'h0, 2, 2);
    rd(`ODT_OFS_OFF_ELAPSED, 32'h0);
    drv(4'h0);
  endtask
  task automatic sc_pwr;
    drv(4'h4);
    wait_q(1, 1'h1, 2, 2);
    drv(4'h0);
    repeat (4) @(posedge clk_i);
    drv(4'h1);
    wait_q(1, 1'h0, 2, 2);
    rd(`ODT_OFS_OFF_ELAPSED, 32'h0);
    drv(4'h0);
    wr(`ODT_OFS_OFF_CFG, 32'h8);
    drv(4'h4);
    wait_q(1, 1'h1, 2, 2);
    drv(4'h0);
    repeat (4) @(posedge clk_i);
    drv(4'h1);
    repeat (40) @(posedge clk_i);
    chk(off_q_o, 32'h1);
    drv(4'h0);
    wait_q(1, 1'h0, 2 * TC, 6 * TC + 4);
    wr(`ODT_OFS_OFF_CFG, 32'h0);
  endtask
  task automatic sc_src;
    odt_nbr_model_inst.set_blk(2, 32'h28);
    wr(`ODT_OFS_ON_CFG, 32'h00000204);
    drv(4'h8);
    wait_q(0, 1'h1, 3 * TC, 5 * TC + 4);
    drv(4'h0);
    odt_nbr_model_inst.set_blk(2, 32'hFFFFFFF9);
    wait_q(0, 1'h0, 2, 2);
    drv(4'h8);
    wait_q(0, 1'h1, 1, 6);
    drv(4'h0);
    odt_nbr_model_inst.set_blk(2, 32'h7FFFFFFF);
    wait_q(0, 1'h0, 2, 2);
    drv(4'h8);
    wait_q(0, 1'h1, 9999 * TC, 9999 * TC + 3);
    drv(4'h0);
    odt_nbr_model_inst.set_blk(2, 32'h1);
    wr(`ODT_OFS_ON_CFG, {30'h81, `ODT_TB_MIN});
    drv(4'h8);
    wait_q(0, 1'h1, 1, 6000 * TC + 8);
    drv(4'h0);
    wr(`ODT_OFS_ON_CFG, {30'h0, `ODT_TB_SEC});
    wr(`ODT_OFS_ON_DELAY, 32'h2);
    drv(4'h8);
    wait_q(0, 1'h1, 100 * TC, 300 * TC + 8);
    drv(4'h0);
    wait_q(0, 1'h0, 2, 2);
  endtask

  initial
  begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    sc_regs();
    sc_on();
    sc_off();
    sc_pwr();
    sc_src();
    tally_and_finish();
  end
endmodule
